/* File: rtl/xld_pkg.sv */
// Constants and types of the exclusive-OR datapath
package xld_pkg;

  // ==========================================================
  // Sizes
  localparam int ACC_W  = 40;
  localparam int AUX_W  = 16;
  localparam int K8_W   = 8;
  localparam int SH_W   = 6;
  localparam int ACC_N  = 4;
  localparam int AUX_N  = 4;
  localparam int MEM_N  = 16;
  localparam int ADDR_W = 8;
  localparam int REP_W  = 8;
  localparam int CNT_W  = 16;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSN = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_REP  = 8'h0C;
  localparam logic [7:0] OFS_ACCL = 8'h10;
  localparam logic [7:0] OFS_ACCH = 8'h20;
  localparam logic [7:0] OFS_AUX  = 8'h30;
  localparam logic [7:0] OFS_MEM  = 8'h40;
  localparam logic [7:0] OFS_END  = 8'h80;

  // ==========================================================
  // Field positions and reset values
  localparam int STAT_POS_BUSY    = 0;
  localparam int STAT_POS_ILLEGAL = 1;
  localparam int STAT_POS_COUNT   = 16;
  localparam logic [2:0]       CTRL_RESET = 3'h0;
  localparam logic [REP_W-1:0] REP_RESET  = 8'h00;
  localparam logic [31:0]      INSN_RESET = 32'h0000_0000;

  // ==========================================================
  // Opcodes and bus answers
  localparam logic [6:0] OPC7_REG   = 7'h16;
  localparam logic [6:0] OPC7_K8    = 7'h0E;
  localparam logic [6:0] OPC7_SHIFT = 7'h08;
  localparam logic [7:0] OPC_K16    = 8'h7F;
  localparam logic [7:0] OPC_MEM    = 8'hF6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    FORM_REG   = 3'h0,
    FORM_K8    = 3'h1,
    FORM_K16   = 3'h2,
    FORM_SHIFT = 3'h3,
    FORM_MEM   = 3'h4
  } xld_form_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } xld_state_e;

  typedef struct packed {
    logic carry;
    logic legacy_compat_mode;
    logic wide_overflow_mode;
  } xld_ctrl_s;

  typedef struct packed {
    logic [7:0]  opcode;
    logic        spare;
    logic [2:0]  dst;
    logic [3:0]  src;
    logic [15:0] imm;
  } xld_insn_s;

  typedef struct packed {
    xld_form_e   form;
    logic        dst_acc;
    logic        src_acc;
    logic [39:0] dst_val;
    logic [39:0] src_val;
    logic [15:0] imm;
    logic        wide_overflow_mode;
    logic        legacy_compat_mode;
  } xld_alu_in_s;

endpackage

/* File: rtl/xld_alu.sv */
// Combinational exclusive-OR unit for all instruction forms
`timescale 1ns/1ns
module xld_alu (
  input  xld_pkg::xld_alu_in_s op,
  output logic [39:0]          result
);

  logic [39:0] ext_src;
  logic [39:0] x_in;
  logic [39:0] shifted;
  logic [5:0]  mag;
  logic        narrow;

  // ==========================================================
  // Operand shaping and shift
  always_comb begin
    narrow  = ~op.wide_overflow_mode & ~op.legacy_compat_mode;
    ext_src = op.src_acc ? op.src_val : {24'h00_0000, op.src_val[15:0]};
    x_in    = narrow ? {8'h00, op.src_val[31:0]} : op.src_val;
    mag     = op.imm[5] ? (6'h00 - op.imm[5:0]) : op.imm[5:0];
    shifted = op.imm[5] ? (x_in >> mag) : (x_in << mag);
    if (narrow) begin
      shifted[39:32] = 8'h00;
    end
  end

  // ==========================================================
  // Result per form
  always_comb begin
    unique case (op.form)
      xld_pkg::FORM_REG: begin
        if (op.dst_acc) begin
          result = op.dst_val ^ ext_src;
        end else begin
          result = {24'h00_0000, op.dst_val[15:0] ^ op.src_val[15:0]};
        end
      end
      xld_pkg::FORM_K8: begin
        if (op.dst_acc) begin
          result = ext_src ^ {32'h0000_0000, op.imm[7:0]};
        end else begin
          result = {24'h00_0000, op.src_val[15:0] ^ {8'h00, op.imm[7:0]}};
        end
      end
      xld_pkg::FORM_K16: begin
        if (op.dst_acc) begin
          result = ext_src ^ {24'h00_0000, op.imm};
        end else begin
          result = {24'h00_0000, op.src_val[15:0] ^ op.imm};
        end
      end
      xld_pkg::FORM_SHIFT: begin
        result = op.dst_val ^ shifted;
      end
      default: begin
        result = {24'h00_0000, op.src_val[15:0] ^ op.imm};
      end
    endcase
  end

endmodule // xld_alu

/* File: rtl/xld_xor_datapath.sv */
// Exclusive-OR datapath with register file, data memory and AXI4-Lite slave
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module xld_xor_datapath (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [xld_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [xld_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            exec_busy
);

  // ==========================================================
  // State
  logic [39:0]               acc_reg [xld_pkg::ACC_N];
  logic [39:0]               acc_next [xld_pkg::ACC_N];
  logic [15:0]               aux_reg [xld_pkg::AUX_N];
  logic [15:0]               aux_next [xld_pkg::AUX_N];
  logic [15:0]               mem_reg [xld_pkg::MEM_N];
  logic [15:0]               mem_next [xld_pkg::MEM_N];
  xld_pkg::xld_ctrl_s        ctrl_reg, ctrl_next;
  xld_pkg::xld_insn_s        insn_reg, insn_next;
  logic [7:0]                rep_reg, rep_next;
  logic [7:0]                rep_cnt_reg, rep_cnt_next;
  logic                      illegal_reg, illegal_next;
  logic [15:0]               count_reg, count_next;
  xld_pkg::xld_state_e       state_reg, state_next;
  logic                      aw_held_reg, aw_held_next;
  logic [7:0]                awaddr_reg, awaddr_next;
  logic                      w_held_reg, w_held_next;
  logic [31:0]               wdata_reg, wdata_next;
  logic [3:0]                wstrb_reg, wstrb_next;
  logic                      bvalid_reg, bvalid_next;
  logic [1:0]                bresp_reg, bresp_next;
  logic                      rvalid_reg, rvalid_next;
  logic [31:0]               rdata_reg, rdata_next;
  logic [1:0]                rresp_reg, rresp_next;

  logic [7:0]                mux_addr [2];
  logic [31:0]               mux_data [2];
  logic                      mux_hit [2];
  logic [7:0]                wa;
  logic [31:0]               wmerge;
  logic                      wr_go;
  logic                      wr_ok;
  logic                      go_ok;
  logic [3:0]                dec_ins;
  logic [3:0]                dec_new;
  xld_pkg::xld_alu_in_s      alu_in;
  logic [39:0]               alu_result;

  // ==========================================================
  // Opcode decode: legal flag and form
  function automatic logic [3:0] decode(input logic [7:0] opc);
    logic [3:0] d;
    d = {1'b0, xld_pkg::FORM_REG};
    if (opc[7:1] == xld_pkg::OPC7_REG) begin
      d = {1'b1, xld_pkg::FORM_REG};
    end else if (opc[7:1] == xld_pkg::OPC7_K8) begin
      d = {1'b1, xld_pkg::FORM_K8};
    end else if (opc == xld_pkg::OPC_K16) begin
      d = {1'b1, xld_pkg::FORM_K16};
    end else if (opc[7:1] == xld_pkg::OPC7_SHIFT) begin
      d = {1'b1, xld_pkg::FORM_SHIFT};
    end else if (opc == xld_pkg::OPC_MEM) begin
      d = {1'b1, xld_pkg::FORM_MEM};
    end
    return d;
  endfunction

  assign dec_ins = decode(insn_reg.opcode);
  assign dec_new = decode(wmerge[31:24]);

  // ==========================================================
  // Operand fetch
  always_comb begin
    alu_in.form    = xld_pkg::xld_form_e'(dec_ins[2:0]);
    alu_in.dst_acc = ~insn_reg.dst[2] | (alu_in.form == xld_pkg::FORM_SHIFT);
    alu_in.src_acc = ~insn_reg.src[2] | (alu_in.form == xld_pkg::FORM_SHIFT);
    alu_in.dst_val = alu_in.dst_acc ? acc_reg[insn_reg.dst[1:0]] : {24'h00_0000, aux_reg[insn_reg.dst[1:0]]};
    if (alu_in.form == xld_pkg::FORM_MEM) begin
      alu_in.src_val = {24'h00_0000, mem_reg[insn_reg.src]};
    end else if (alu_in.src_acc) begin
      alu_in.src_val = acc_reg[insn_reg.src[1:0]];
    end else begin
      alu_in.src_val = {24'h00_0000, aux_reg[insn_reg.src[1:0]]};
    end
    alu_in.imm                = insn_reg.imm;
    alu_in.wide_overflow_mode = ctrl_reg.wide_overflow_mode;
    alu_in.legacy_compat_mode = ctrl_reg.legacy_compat_mode;
  end

  xld_alu u_alu (
    .op     (alu_in),
    .result (alu_result)
  );

  // ==========================================================
  // Register read mux for the read port and the write merge
  assign mux_addr[0] = {s_axi_araddr[7:2], 2'b00};
  assign mux_addr[1] = wa;
  assign wa          = {awaddr_reg[7:2], 2'b00};

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      mux_hit[k]  = 1'b1;
      mux_data[k] = 32'h0000_0000;
      if (mux_addr[k] == xld_pkg::OFS_CTRL) begin
        mux_data[k][2:0] = ctrl_reg;
      end else if (mux_addr[k] == xld_pkg::OFS_INSN) begin
        mux_data[k] = insn_reg;
      end else if (mux_addr[k] == xld_pkg::OFS_STAT) begin
        mux_data[k][xld_pkg::STAT_POS_BUSY]    = (state_reg == xld_pkg::ST_EXEC);
        mux_data[k][xld_pkg::STAT_POS_ILLEGAL] = illegal_reg;
        mux_data[k][xld_pkg::STAT_POS_COUNT+:16] = count_reg;
      end else if (mux_addr[k] == xld_pkg::OFS_REP) begin
        mux_data[k][7:0] = rep_reg;
      end else if (mux_addr[k] < xld_pkg::OFS_ACCH) begin
        mux_data[k] = acc_reg[mux_addr[k][3:2]][31:0];
      end else if (mux_addr[k] < xld_pkg::OFS_AUX) begin
        mux_data[k][7:0] = acc_reg[mux_addr[k][3:2]][39:32];
      end else if (mux_addr[k] < xld_pkg::OFS_MEM) begin
        mux_data[k][15:0] = aux_reg[mux_addr[k][3:2]];
      end else if (mux_addr[k] < xld_pkg::OFS_END) begin
        mux_data[k][15:0] = mem_reg[mux_addr[k][5:2]];
      end else begin
        mux_hit[k] = 1'b0;
      end
    end
  end

  // Byte-lane merge of write data
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmerge[8*b+:8] = wstrb_reg[b] ? wdata_reg[8*b+:8] : mux_data[1][8*b+:8];
  end

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign exec_busy     = (state_reg == xld_pkg::ST_EXEC);
  assign wr_go         = aw_held_reg & w_held_reg;
  assign wr_ok         = mux_hit[1] & (state_reg == xld_pkg::ST_IDLE) & (wa != xld_pkg::OFS_STAT);
  assign go_ok         = wr_go & wr_ok & (wa == xld_pkg::OFS_INSN) & dec_new[3];

  // ==========================================================
  // Next-state logic
  always_comb begin
    acc_next     = acc_reg;
    aux_next     = aux_reg;
    mem_next     = mem_reg;
    ctrl_next    = ctrl_reg;
    insn_next    = insn_reg;
    rep_next     = rep_reg;
    rep_cnt_next = rep_cnt_reg;
    illegal_next = illegal_reg;
    count_next   = count_reg;
    state_next   = state_reg;
    aw_held_next = aw_held_reg | (s_axi_awvalid & s_axi_awready);
    awaddr_next  = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_reg;
    w_held_next  = w_held_reg | (s_axi_wvalid & s_axi_wready);
    wdata_next   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_reg;
    wstrb_next   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_reg;
    bvalid_next  = bvalid_reg & ~s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg & ~s_axi_rready;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // Read channel
    if (s_axi_arvalid & s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next  = mux_data[0];
      rresp_next  = mux_hit[0] ? xld_pkg::RESP_OKAY : xld_pkg::RESP_SLVERR;
    end
    // One instruction step per cycle, carry never touched
    if (state_reg == xld_pkg::ST_EXEC) begin
      if (alu_in.form == xld_pkg::FORM_MEM) begin
        mem_next[insn_reg.src] = alu_result[15:0];
      end else if (alu_in.dst_acc) begin
        acc_next[insn_reg.dst[1:0]] = alu_result;
      end else begin
        aux_next[insn_reg.dst[1:0]] = alu_result[15:0];
      end
      count_next = count_reg + 16'h0001;
      if (rep_cnt_reg == 8'h00) begin
        state_next = xld_pkg::ST_IDLE;
      end else begin
        rep_cnt_next = rep_cnt_reg - 8'h01;
      end
    end
    // Write channel, refused while executing
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok ? xld_pkg::RESP_OKAY : xld_pkg::RESP_SLVERR;
      if (wr_ok) begin
        if (wa == xld_pkg::OFS_CTRL) begin
          ctrl_next = wmerge[2:0];
        end else if (wa == xld_pkg::OFS_INSN) begin
          insn_next    = wmerge;
          illegal_next = ~dec_new[3];
          if (dec_new[3]) begin
            state_next   = xld_pkg::ST_EXEC;
            rep_cnt_next = rep_reg;
          end
        end else if (wa == xld_pkg::OFS_REP) begin
          rep_next = wmerge[7:0];
        end else if (wa < xld_pkg::OFS_ACCH) begin
          acc_next[wa[3:2]][31:0] = wmerge;
        end else if (wa < xld_pkg::OFS_AUX) begin
          acc_next[wa[3:2]][39:32] = wmerge[7:0];
        end else if (wa < xld_pkg::OFS_MEM) begin
          aux_next[wa[3:2]] = wmerge[15:0];
        end else begin
          mem_next[wa[5:2]] = wmerge[15:0];
        end
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg     <= '{default: 40'h00_0000_0000};
      aux_reg     <= '{default: 16'h0000};
      mem_reg     <= '{default: 16'h0000};
      ctrl_reg    <= xld_pkg::CTRL_RESET;
      insn_reg    <= xld_pkg::INSN_RESET;
      rep_reg     <= xld_pkg::REP_RESET;
      rep_cnt_reg <= 8'h00;
      illegal_reg <= 1'b0;
      count_reg   <= 16'h0000;
      state_reg   <= xld_pkg::ST_IDLE;
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= xld_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= xld_pkg::RESP_OKAY;
    end else begin
      acc_reg     <= acc_next;
      aux_reg     <= aux_next;
      mem_reg     <= mem_next;
      ctrl_reg    <= ctrl_next;
      insn_reg    <= insn_next;
      rep_reg     <= rep_next;
      rep_cnt_reg <= rep_cnt_next;
      illegal_reg <= illegal_next;
      count_reg   <= count_next;
      state_reg   <= state_next;
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic       ex;
  logic [1:0] dq;
  assign ex = (state_reg == xld_pkg::ST_EXEC);
  assign dq = insn_reg.dst[1:0];

  sequence s_exec_more;
    ex && rep_cnt_reg != 8'h00;
  endsequence
  sequence s_exec_last;
    ex && rep_cnt_reg == 8'h00;
  endsequence
  sequence s_insn_go;
    go_ok && rep_reg == 8'h02;
  endsequence

  a_carry_kept: assert property (ex |=> ctrl_reg == $past(ctrl_reg))
    else $error("carry or mode changed during execution");
  a_reg_acc_xor: assert property (ex && alu_in.form == xld_pkg::FORM_REG && alu_in.dst_acc && alu_in.src_acc
    |=> acc_reg[$past(dq)] == ($past(alu_in.dst_val) ^ $past(alu_in.src_val)))
    else $error("register form accumulator result wrong");
  a_aux_src_zext: assert property (ex && alu_in.form == xld_pkg::FORM_REG && alu_in.dst_acc && !alu_in.src_acc
    |=> acc_reg[$past(dq)][39:16] == $past(alu_in.dst_val[39:16]))
    else $error("auxiliary source not zero-filled");
  a_aux_dst_narrow: assert property (ex && alu_in.form == xld_pkg::FORM_REG && !alu_in.dst_acc
    |=> aux_reg[$past(dq)] == ($past(alu_in.dst_val[15:0]) ^ $past(alu_in.src_val[15:0])))
    else $error("16-bit destination result wrong");
  a_k8_zext: assert property (ex && alu_in.form == xld_pkg::FORM_K8 && alu_in.dst_acc
    |=> acc_reg[$past(dq)] == ($past(alu_in.src_val) ^ {32'h0000_0000, $past(insn_reg.imm[7:0])}))
    else $error("short immediate result wrong");
  a_k16_zext: assert property (ex && alu_in.form == xld_pkg::FORM_K16 && alu_in.dst_acc
    |=> acc_reg[$past(dq)] == ($past(alu_in.src_val) ^ {24'h00_0000, $past(insn_reg.imm)}))
    else $error("long immediate result wrong");
  a_shift_narrow: assert property (ex && alu_in.form == xld_pkg::FORM_SHIFT && ctrl_reg[1:0] == 2'h0
    |=> acc_reg[$past(dq)][39:32] == $past(alu_in.dst_val[39:32]))
    else $error("narrow shift upper bits not cleared");
  a_shift_compat: assert property (ex && alu_in.form == xld_pkg::FORM_SHIFT && ctrl_reg.legacy_compat_mode
    && insn_reg.imm[5:0] == 6'h00 |=> acc_reg[$past(dq)] == ($past(alu_in.dst_val) ^ $past(alu_in.src_val)))
    else $error("legacy mode dropped upper bits");
  a_shift_left: assert property (ex && alu_in.form == xld_pkg::FORM_SHIFT && ctrl_reg.wide_overflow_mode
    && insn_reg.imm[5:0] == 6'h01 |=> acc_reg[$past(dq)] == ($past(alu_in.dst_val) ^ {$past(alu_in.src_val[38:0]), 1'b0}))
    else $error("shifted form result wrong");
  a_shift_right: assert property (ex && alu_in.form == xld_pkg::FORM_SHIFT && ctrl_reg.wide_overflow_mode
    && insn_reg.imm[5:0] == 6'h3F |=> acc_reg[$past(dq)] == ($past(alu_in.dst_val) ^ {1'b0, $past(alu_in.src_val[39:1])}))
    else $error("negative shift not to the right");
  a_mem_rmw: assert property (ex && alu_in.form == xld_pkg::FORM_MEM
    |=> mem_reg[$past(insn_reg.src)] == ($past(alu_in.src_val[15:0]) ^ $past(insn_reg.imm)))
    else $error("memory form result wrong");
  a_repeat_step: assert property (s_exec_more |=> ex && rep_cnt_reg == $past(rep_cnt_reg) - 8'h01)
    else $error("repeat count not stepped");
  a_repeat_end: assert property (s_exec_last |=> !ex)
    else $error("execution did not end");
  a_repeat_len: assert property (s_insn_go |=> ex [*3] ##1 !ex)
    else $error("repeated instruction ran wrong number of cycles");

endmodule // xld_xor_datapath

/* File: test/xld_axi_host.sv */
// AXI4-Lite master model standing in for software
`timescale 1ns/1ns
module xld_axi_host (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
  end
  // ==========================================================
  // Write: AW and W offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      @(posedge clk);
      if (pa && ta === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && tw === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      ta = bvalid;
      r = bresp;
      @(posedge clk);
    end while (ta !== 1'b1);
    bready <= 1'b0;
  endtask
  // ==========================================================
  // Read: AR held until taken, rready held until rvalid
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (t !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (t !== 1'b1);
    rready <= 1'b0;
  endtask
endmodule // xld_axi_host

/* File: test/xld_xor_datapath_bench.sv */
// Self-checking bench of the exclusive-OR datapath
`timescale 1ns/1ns
module xld_xor_datapath_bench;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [39:0] v;
  int miscompares, checked, cycles;
  xld_axi_host host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  xld_xor_datapath uut (.clk, .nrst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .exec_busy(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================================
  // Helpers
  task chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x);
    host.wr(a, x, r);
    chk("bresp", 40'(xld_pkg::RESP_OKAY), 40'(r));
  endtask
  task rd(input logic [7:0] a);
    host.rd(a, d, r);
    chk("rresp", 40'(xld_pkg::RESP_OKAY), 40'(r));
  endtask
  task acc(input int i);
    logic [31:0] lo;
    rd(8'(xld_pkg::OFS_ACCL + 4 * i));
    lo = d;
    rd(8'(xld_pkg::OFS_ACCH + 4 * i));
    v = {d[7:0], lo};
  endtask
  task setacc(input int i, input logic [39:0] x);
    wr(8'(xld_pkg::OFS_ACCL + 4 * i), x[31:0]);
    wr(8'(xld_pkg::OFS_ACCH + 4 * i), {24'h00_0000, x[39:32]});
  endtask
  task run(input logic [7:0] op, input logic [2:0] ds, input logic [3:0] s, input logic [15:0] k);
    int n;
    n = 0;
    wr(xld_pkg::OFS_INSN, {op, 1'b0, ds, s, k});
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_forms;
    setacc(0, 40'h7e_2355_4fc0);
    setacc(1, 40'h0f_e340_5678);
    run(8'h2c, 3'h1, 4'h0, 16'h0000);
    acc(1);
    chk("reg_acc1", 40'h71_c015_19b8, v);
    wr(xld_pkg::OFS_AUX, 32'h0000_1234);
    run(8'h1c, 3'h2, 4'h4, 16'h00ff);
    acc(2);
    chk("k8_acc2", 40'h00_0000_12cb, v);
    run(8'h7f, 3'h5, 4'h1, 16'hffff);
    rd(8'(xld_pkg::OFS_AUX + 4));
    chk("k16_aux1", 40'h00_0000_e647, {8'h00, d});
  endtask
  task t_shift;
    wr(xld_pkg::OFS_CTRL, 32'h0000_0004);
    run(8'h10, 3'h3, 4'h0, 16'h0004);
    acc(3);
    chk("shl_narrow", 40'h00_3554_fc00, v);
    wr(xld_pkg::OFS_CTRL, 32'h0000_0006);
    run(8'h10, 3'h3, 4'h0, 16'h003c);
    acc(3);
    chk("shr_legacy", 40'h07_d761_a8fc, v);
    wr(xld_pkg::OFS_CTRL, 32'h0000_0005);
    run(8'h10, 3'h3, 4'h0, 16'h0004);
    acc(3);
    chk("shl_wide", 40'he5_e235_54fc, v);
    rd(xld_pkg::OFS_CTRL);
    chk("ctrl_carry", 40'h00_0000_0005, {8'h00, d});
  endtask
  task t_mem;
    wr(xld_pkg::OFS_REP, 32'h0000_0002);
    wr(8'(xld_pkg::OFS_MEM + 12), 32'h0000_5678);
    run(8'hf6, 3'h0, 4'h3, 16'hffff);
    rd(8'(xld_pkg::OFS_MEM + 12));
    chk("mem_rep3", 40'h00_0000_a987, {8'h00, d});
    host.rd(8'h80, d, r);
    chk("unmapped", 40'(xld_pkg::RESP_SLVERR), 40'(r));
  endtask
  task stop_test;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_forms();
    t_shift();
    t_mem();
    stop_test();
  end
endmodule // xld_xor_datapath_bench
